/* logic/rcs_regs.svh */
// Register offsets, field positions, reset values and timing counts of the
// reset cause and start-up sequencer.
// Assumes inclusion by bare name from every file that needs the constants.
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH

// ==========================================================================
// Register indices; the byte address is four times the index.
`define RCS_BROWNOUT_CONTROL_IDX 12'he4b
`define RCS_CAUSE_IDX 12'hfd7

// ==========================================================================
// Field positions.
`define RCS_BIT_SW_BOR_EN 7
`define RCS_BIT_BOR_READY 0
`define RCS_BIT_OVF 7
`define RCS_BIT_UNF 6
`define RCS_BIT_WV 5
`define RCS_BIT_RI 2

// ==========================================================================
// Reset values.
`define RCS_CAUSE_RST 8'h3d
`define RCS_BROWNOUT_CONTROL_RST 8'h80

// ==========================================================================
// Cause flag effects per event: mask of touched bits, then their values.
`define RCS_CM_POR 8'hfe
`define RCS_CV_POR 8'h3c
`define RCS_CM_BOR 8'hfd
`define RCS_CV_BOR 8'h3c
`define RCS_CM_REG 8'hfe
`define RCS_CV_REG 8'h32
`define RCS_CM_PIN 8'h08
`define RCS_CM_WDT 8'h10
`define RCS_CM_WV 8'h20
`define RCS_CM_RI 8'h04
`define RCS_CM_OVF 8'h80
`define RCS_CM_UNF 8'h40

// ==========================================================================
// Core status effects per event: mask of loaded bits, then their values.
`define RCS_SM_POR 8'h7f
`define RCS_SV_POR 8'h60
`define RCS_SM_PINS 8'h60
`define RCS_SV_PINS 8'h40
`define RCS_SM_WDT 8'h40
`define RCS_SM_WWAKE 8'h60
`define RCS_SM_IWAKE 8'h68
`define RCS_SV_IWAKE 8'h40
`define RCS_SM_REG 8'h1f
`define RCS_SV_REG 8'h18

// ==========================================================================
// Timing.
`define RCS_CLK_HZ 125000000
`define RCS_SLOW_OSC_HZ 31000
`define RCS_SLOW_DIV (`RCS_CLK_HZ / `RCS_SLOW_OSC_HZ)
`define RCS_POWERUP_TIMER_TICKS 2048
`define RCS_POWERUP_TIMER_NOM_MS 66
`define RCS_PIN_DLY_CYC 10

`endif

/* logic/rcs_pkg.sv */
// Types shared by the reset cause and start-up sequencer.
// Assumes nothing of its surroundings.
package rcs_pkg;

	// ======================================================================
	// Sequencer states.
	typedef enum logic [2:0] {
		rcs_st_hold = 3'h0,
		rcs_st_powerup_timer = 3'h1,
		rcs_st_ost = 3'h2,
		rcs_st_pin = 3'h3,
		rcs_st_dly = 3'h4,
		rcs_st_run = 3'h5
	} rcs_state_t;

	// ======================================================================
	// Detected events, highest priority first.
	typedef enum logic [3:0] {
		rcs_ev_none = 4'h0,
		rcs_ev_por = 4'h1,
		rcs_ev_bor = 4'h2,
		rcs_ev_reg = 4'h3,
		rcs_ev_fuse = 4'h4,
		rcs_ev_pin = 4'h5,
		rcs_ev_pins = 4'h6,
		rcs_ev_wdt = 4'h7,
		rcs_ev_wv = 4'h8,
		rcs_ev_ri = 4'h9,
		rcs_ev_ovf = 4'ha,
		rcs_ev_unf = 4'hb,
		rcs_ev_wwake = 4'hc,
		rcs_ev_iwake = 4'hd
	} rcs_ev_t;

	// ======================================================================
	// Program counter action presented with a load pulse.
	typedef enum logic [1:0] {
		rcs_pc_zero = 2'h0,
		rcs_pc_next = 2'h1,
		rcs_pc_vector = 2'h2
	} rcs_pc_t;

endpackage

/* logic/rcs_divider.sv */
// Divider that turns the system clock into a one-cycle enable pulse at the
// slow internal oscillator rate.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module rcs_divider #(
	parameter int DIV = 4032
)(
	input wire logic hclk,
	input wire logic hresetn,
	output logic tick
);
	localparam int W = $clog2(DIV + 1);

	logic [W-1:0] cnt;

	generate
		if (DIV < 2) begin : g_bad
			$error("rcs_divider needs DIV of at least 2");
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (cnt == W'(DIV - 1)) begin
			cnt <= '0;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + W'(1);
			tick <= 1'b0;
		end
	end
endmodule

/* logic/rcs_delay.sv */
// One-shot counter: after start it counts COUNT enable ticks and then
// raises done for one cycle.
// Assumes start is a synchronous one-cycle pulse and tick a synchronous enable that may stay high.
`timescale 1ns/1ps
module rcs_delay #(
	parameter int COUNT = 10
)(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic start,
	input wire logic tick,
	output logic done
);
	localparam int W = $clog2(COUNT + 1);

	logic [W-1:0] cnt;
	logic busy;

	generate
		if (COUNT < 1) begin : g_bad
			$error("rcs_delay needs COUNT of at least 1");
		end
	endgenerate

	// Done is combinational so that the owner leaves its state on the very
	// edge of the last tick.
	assign done = busy && tick && (cnt == '0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= '0;
			busy <= 1'b0;
		end else if (start) begin
			cnt <= W'(COUNT - 1);
			busy <= 1'b1;
		end else if (busy && tick) begin
			if (cnt == '0) begin
				busy <= 1'b0;
			end else begin
				cnt <= cnt - W'(1);
			end
		end
	end
endmodule

/* logic/rcs_sequencer.sv */
// Reset cause flags, brown-out control and start-up sequencer with an
// AHB-Lite register slave.
// Assumes all event inputs are synchronous to hclk; event pulses last one
// cycle and level inputs are held by their sources.
`timescale 1ns/1ps
`include "rcs_regs.svh"

// How it works
// - Reset instruction resets, clears its flag only.
// - Stack overflow/underflow reset and set flags when enabled.
// - Leaving programming mode acts as power-on.
// - Power-up timer waits 2048 slow oscillator cycles.
// - Core stays in reset while timer runs.
// - Timer starts after power-on and brown-out release.
// - Run needs timer, oscillator start and pin.
// - Timers ignore pin; run ten cycles after.
// - Power-on and brown-out load their status patterns.
// - Pin reset clears its flag; sleep loads status.
// - Watchdog time-out and window violation clear flags.
// - Watchdog wake continues at next, no reset.
// - Interrupt wake continues, vectors if enabled.
// - Regulator fault resets with its patterns.
// - Fuse fault resets, leaves both registers.
// - Zero, carry flags reset by power and regulator fault.
// - Only the matching cause flags change.
// - Software writes only store, never reset.
// - Low-active flags clear on cause, power sets.
// - Clear while window closed flags violation.
// - Stack flags high-active, cleared by power.
// - Software brown-out enable acts only in mode 01.
// - Ready bit shows brown-out circuit armed.
// - Brown-out and power-on flags low-active.
module rcs_sequencer #(
	parameter int POWERUP_TIMER_TICKS = `RCS_POWERUP_TIMER_TICKS,
	parameter int SLOW_DIV = `RCS_SLOW_DIV,
	parameter int PIN_DLY = `RCS_PIN_DLY_CYC
)(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [15:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic por_active,
	input wire logic bor_active,
	input wire logic prog_mode_exit,
	input wire logic ext_reset_pin_n,
	input wire logic pin_reset_enable,
	input wire logic powerup_timer_disable_n,
	input wire logic osc_startup_required,
	input wire logic osc_startup_done,
	input wire logic stack_reset_enable,
	input wire logic stack_overflow,
	input wire logic stack_underflow,
	input wire logic reset_instr,
	input wire logic wdt_timeout,
	input wire logic watchdog_clear_op,
	input wire logic wdt_window_closed,
	input wire logic sleeping,
	input wire logic int_wakeup,
	input wire logic global_int_enable,
	input wire logic int_high_priority,
	input wire logic regulator_fault,
	input wire logic fuse_fault,
	input wire logic [1:0] brownout_config,
	input wire logic brownout_circuit_ready,
	output logic core_reset,
	output logic pc_load,
	output rcs_pkg::rcs_pc_t pc_sel,
	output logic vector_high,
	output logic status_load,
	output logic [7:0] status_mask,
	output logic [7:0] status_value,
	output logic brownout_detector_enable
);
	// ======================================================================
	// Parameter checks.
	generate
		if (POWERUP_TIMER_TICKS < 1 || SLOW_DIV < 2 || PIN_DLY < 1) begin : g_bad
			$error("rcs_sequencer parameters out of range");
		end
	endgenerate

	// ======================================================================
	// Declarations.
	rcs_pkg::rcs_state_t state;
	rcs_pkg::rcs_state_t next_state;
	rcs_pkg::rcs_ev_t ev;
	logic [7:0] reset_cause_reg;
	logic sw_brownout_enable;
	logic brownout_ready;
	logic [31:0] fx;
	logic soft_reset;
	logic wake;
	logic window_violation;
	logic slow_tick;
	logic powerup_timer_start;
	logic powerup_timer_done;
	logic dly_start;
	logic dly_done;
	logic addr_ok;
	logic wr_pend;
	logic [1:0] wr_sel;
	logic wr_cause;
	logic wr_brownout_control;
	logic [7:0] cause_sw;
	// A literal cannot be bit-selected, so the reset value gets a name.
	localparam logic [7:0] BROWNOUT_CONTROL_RST = `RCS_BROWNOUT_CONTROL_RST;

	// ======================================================================
	// Register decode: 0 unmapped, 1 cause flags, 2 brown-out control.
	function automatic logic [1:0] reg_sel(input logic [15:0] a);
		if (a[15:14] != 2'h0 || a[1:0] != 2'h0) begin
			reg_sel = 2'h0;
		end else if (a[13:2] == `RCS_CAUSE_IDX) begin
			reg_sel = 2'h1;
		end else if (a[13:2] == `RCS_BROWNOUT_CONTROL_IDX) begin
			reg_sel = 2'h2;
		end else begin
			reg_sel = 2'h0;
		end
	endfunction

	// Effect of an event: cause mask, cause value, status mask, status value.
	// Status bits outside a mask are left to the core; the power-on mask
	// leaves only bit 7 outside, so zero and carry are loaded there.
	function automatic logic [31:0] ev_effect(input rcs_pkg::rcs_ev_t e);
		unique case (e)
			rcs_pkg::rcs_ev_por: ev_effect = {`RCS_CM_POR, `RCS_CV_POR,
				`RCS_SM_POR, `RCS_SV_POR};
			rcs_pkg::rcs_ev_bor: ev_effect = {`RCS_CM_BOR, `RCS_CV_BOR,
				`RCS_SM_POR, `RCS_SV_POR};
			rcs_pkg::rcs_ev_reg: ev_effect = {`RCS_CM_REG, `RCS_CV_REG,
				`RCS_SM_REG, `RCS_SV_REG};
			rcs_pkg::rcs_ev_fuse: ev_effect = 32'h0000_0000;
			rcs_pkg::rcs_ev_pin: ev_effect = {`RCS_CM_PIN, 24'h00_0000};
			rcs_pkg::rcs_ev_pins: ev_effect = {`RCS_CM_PIN, 8'h00,
				`RCS_SM_PINS, `RCS_SV_PINS};
			rcs_pkg::rcs_ev_wdt: ev_effect = {`RCS_CM_WDT, 8'h00,
				`RCS_SM_WDT, 8'h00};
			rcs_pkg::rcs_ev_wv: ev_effect = {`RCS_CM_WV, 24'h00_0000};
			rcs_pkg::rcs_ev_ri: ev_effect = {`RCS_CM_RI, 24'h00_0000};
			rcs_pkg::rcs_ev_ovf: ev_effect = {`RCS_CM_OVF, `RCS_CM_OVF,
				16'h0000};
			rcs_pkg::rcs_ev_unf: ev_effect = {`RCS_CM_UNF, `RCS_CM_UNF,
				16'h0000};
			rcs_pkg::rcs_ev_wwake: ev_effect = {16'h0000, `RCS_SM_WWAKE,
				8'h00};
			rcs_pkg::rcs_ev_iwake: ev_effect = {16'h0000, `RCS_SM_IWAKE,
				`RCS_SV_IWAKE};
			default: ev_effect = 32'h0000_0000;
		endcase
	endfunction

	// ======================================================================
	// Event selection. All sources meet here; only one acts per cycle.
	assign window_violation = watchdog_clear_op && wdt_window_closed;

	always_comb begin
		ev = rcs_pkg::rcs_ev_none;
		if (prog_mode_exit ||
			(por_active && state != rcs_pkg::rcs_st_hold)) begin
			ev = rcs_pkg::rcs_ev_por;
		end else if (bor_active && state != rcs_pkg::rcs_st_hold) begin
			ev = rcs_pkg::rcs_ev_bor;
		end else if (state == rcs_pkg::rcs_st_run) begin
			if (regulator_fault) begin
				ev = rcs_pkg::rcs_ev_reg;
			end else if (fuse_fault) begin
				ev = rcs_pkg::rcs_ev_fuse;
			end else if (pin_reset_enable && !ext_reset_pin_n) begin
				ev = sleeping ? rcs_pkg::rcs_ev_pins
					: rcs_pkg::rcs_ev_pin;
			end else if (wdt_timeout && !sleeping) begin
				ev = rcs_pkg::rcs_ev_wdt;
			end else if (window_violation) begin
				ev = rcs_pkg::rcs_ev_wv;
			end else if (reset_instr) begin
				ev = rcs_pkg::rcs_ev_ri;
			end else if (stack_reset_enable && stack_overflow) begin
				ev = rcs_pkg::rcs_ev_ovf;
			end else if (stack_reset_enable && stack_underflow) begin
				ev = rcs_pkg::rcs_ev_unf;
			end else if (wdt_timeout && sleeping) begin
				ev = rcs_pkg::rcs_ev_wwake;
			end else if (int_wakeup && sleeping) begin
				ev = rcs_pkg::rcs_ev_iwake;
			end
		end
	end

	assign fx = ev_effect(ev);
	assign soft_reset = ev inside {[rcs_pkg::rcs_ev_reg:rcs_pkg::rcs_ev_unf]};
	assign wake = ev inside {rcs_pkg::rcs_ev_wwake, rcs_pkg::rcs_ev_iwake};

	// ======================================================================
	// Start-up timers.
	rcs_divider #(.DIV(SLOW_DIV)) u_slow (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick(slow_tick)
	);

	rcs_delay #(.COUNT(POWERUP_TIMER_TICKS)) u_powerup_timer (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(powerup_timer_start),
		.tick(slow_tick),
		.done(powerup_timer_done)
	);

	rcs_delay #(.COUNT(PIN_DLY)) u_pin_dly (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(dly_start),
		.tick(1'b1),
		.done(dly_done)
	);

	// ======================================================================
	// Sequencer.
	always_comb begin
		next_state = state;
		powerup_timer_start = 1'b0;
		dly_start = 1'b0;
		if (ev == rcs_pkg::rcs_ev_por || ev == rcs_pkg::rcs_ev_bor) begin
			next_state = rcs_pkg::rcs_st_hold;
		end else begin
			unique case (state)
				rcs_pkg::rcs_st_hold: begin
					if (!por_active && !bor_active) begin
						if (!powerup_timer_disable_n) begin
							next_state = rcs_pkg::rcs_st_powerup_timer;
							powerup_timer_start = 1'b1;
						end else begin
							next_state = rcs_pkg::rcs_st_ost;
						end
					end
				end
				rcs_pkg::rcs_st_powerup_timer: begin
					if (powerup_timer_done) begin
						next_state = rcs_pkg::rcs_st_ost;
					end
				end
				rcs_pkg::rcs_st_ost: begin
					if (!osc_startup_required || osc_startup_done) begin
						next_state = rcs_pkg::rcs_st_pin;
					end
				end
				rcs_pkg::rcs_st_pin: begin
					if (!pin_reset_enable || ext_reset_pin_n) begin
						next_state = rcs_pkg::rcs_st_dly;
						dly_start = 1'b1;
					end
				end
				rcs_pkg::rcs_st_dly: begin
					if (dly_done) begin
						next_state = rcs_pkg::rcs_st_run;
					end
				end
				rcs_pkg::rcs_st_run: begin
					if (soft_reset) begin
						next_state = rcs_pkg::rcs_st_pin;
					end
				end
				default: next_state = rcs_pkg::rcs_st_hold;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= rcs_pkg::rcs_st_hold;
			core_reset <= 1'b1;
		end else begin
			state <= next_state;
			core_reset <= next_state != rcs_pkg::rcs_st_run;
		end
	end

	// Program counter and core status loads.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_load <= 1'b0;
			pc_sel <= rcs_pkg::rcs_pc_zero;
			vector_high <= 1'b0;
			status_load <= 1'b0;
			status_mask <= 8'h00;
			status_value <= 8'h00;
		end else begin
			pc_load <= 1'b0;
			status_load <= fx[15:8] != 8'h00;
			status_mask <= fx[15:8];
			status_value <= fx[7:0];
			if (state == rcs_pkg::rcs_st_dly &&
				next_state == rcs_pkg::rcs_st_run) begin
				pc_load <= 1'b1;
				pc_sel <= rcs_pkg::rcs_pc_zero;
			end else if (ev == rcs_pkg::rcs_ev_wwake) begin
				pc_load <= 1'b1;
				pc_sel <= rcs_pkg::rcs_pc_next;
			end else if (ev == rcs_pkg::rcs_ev_iwake) begin
				pc_load <= 1'b1;
				pc_sel <= global_int_enable ? rcs_pkg::rcs_pc_vector
					: rcs_pkg::rcs_pc_next;
				vector_high <= int_high_priority;
			end
		end
	end

	// ======================================================================
	// Cause flags. A hardware event wins over a software write in the same
	// cycle, bit by bit, so that no cause is lost.
	assign cause_sw = wr_cause ? hwdata[7:0] : reset_cause_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reset_cause_reg <= `RCS_CAUSE_RST;
		end else begin
			reset_cause_reg <= (cause_sw & ~fx[31:24]) |
				(fx[23:16] & fx[31:24]);
		end
	end

	// ======================================================================
	// Brown-out control.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_brownout_enable <= BROWNOUT_CONTROL_RST[`RCS_BIT_SW_BOR_EN];
		end else if (ev == rcs_pkg::rcs_ev_por ||
			ev == rcs_pkg::rcs_ev_bor) begin
			sw_brownout_enable <= 1'b1;
		end else if (wr_brownout_control) begin
			sw_brownout_enable <= hwdata[`RCS_BIT_SW_BOR_EN];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			brownout_detector_enable <= 1'b0;
			brownout_ready <= 1'b0;
		end else begin
			unique case (brownout_config)
				2'h3: brownout_detector_enable <= 1'b1;
				2'h2: brownout_detector_enable <= !sleeping;
				2'h1: brownout_detector_enable <= sw_brownout_enable;
				2'h0: brownout_detector_enable <= 1'b0;
			endcase
			brownout_ready <= brownout_detector_enable &&
				brownout_circuit_ready;
		end
	end

	// ======================================================================
	// AHB-Lite slave. Reads and writes complete with no wait state; a read
	// samples the registers at the address phase edge.
	assign addr_ok = hsel && htrans[1] && hreadyout;
	assign wr_cause = wr_pend && wr_sel == 2'h1;
	assign wr_brownout_control = wr_pend && wr_sel == 2'h2;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_sel <= 2'h0;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend <= addr_ok && hwrite && hsize == 3'h2;
			wr_sel <= reg_sel(haddr);
			if (addr_ok && !hwrite) begin
				unique case (reg_sel(haddr))
					2'h1: hrdata <= {24'h00_0000, reset_cause_reg};
					2'h2: hrdata <= {24'h00_0000, sw_brownout_enable,
						6'h00, brownout_ready};
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ======================================================================
	// Checks.
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	int powerup_timer_cyc;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			powerup_timer_cyc <= 0;
		end else if (state != rcs_pkg::rcs_st_powerup_timer) begin
			powerup_timer_cyc <= 0;
		end else begin
			powerup_timer_cyc <= powerup_timer_cyc + 1;
		end
	end

	sequence seq_dly_enter;
		$rose(state == rcs_pkg::rcs_st_dly);
	endsequence

	sequence seq_dly_run;
		##9 (state == rcs_pkg::rcs_st_dly) ##1 (state == rcs_pkg::rcs_st_run)
			##0 !core_reset;
	endsequence

	chk_ri_flag: assert property (
		(ev == rcs_pkg::rcs_ev_ri && !wr_cause) |=>
			!reset_cause_reg[`RCS_BIT_RI] &&
			reset_cause_reg[7:3] == $past(reset_cause_reg[7:3]) &&
			reset_cause_reg[1:0] == $past(reset_cause_reg[1:0]) &&
			state == rcs_pkg::rcs_st_pin && core_reset)
		else $error("reset instruction flag or reset wrong");
	chk_stack_flags: assert property (
		(ev == rcs_pkg::rcs_ev_ovf) |=> reset_cause_reg[`RCS_BIT_OVF] &&
			core_reset)
		else $error("stack overflow flag not set");
	chk_powerup_timer_length: assert property (
		(state == rcs_pkg::rcs_st_powerup_timer && next_state == rcs_pkg::rcs_st_ost)
			|-> (powerup_timer_cyc >= (POWERUP_TIMER_TICKS - 1) * SLOW_DIV &&
			powerup_timer_cyc < POWERUP_TIMER_TICKS * SLOW_DIV))
		else $error("power-up timer length wrong");
	chk_powerup_timer_holds: assert property (
		(state == rcs_pkg::rcs_st_powerup_timer) |-> core_reset)
		else $error("core released during power-up timer");
	chk_powerup_timer_start: assert property (
		$rose(state == rcs_pkg::rcs_st_powerup_timer) |->
			$past(!por_active && !bor_active && !powerup_timer_disable_n))
		else $error("power-up timer started too early");
	chk_pin_release: assert property (
		seq_dly_enter |-> seq_dly_run)
		else $error("release not ten cycles after pin");
	chk_por_load: assert property (
		(ev == rcs_pkg::rcs_ev_por) |=> status_load &&
			status_value == `RCS_SV_POR && status_mask == `RCS_SM_POR &&
			(reset_cause_reg & `RCS_CM_POR) == `RCS_CV_POR)
		else $error("power-on load pattern wrong");
	chk_wake_run: assert property (
		(ev == rcs_pkg::rcs_ev_wwake && !wr_cause) |=> pc_load &&
			pc_sel == rcs_pkg::rcs_pc_next && !core_reset &&
			reset_cause_reg == $past(reset_cause_reg))
		else $error("watchdog wake misbehaved");
	chk_sw_write: assert property (
		(wr_cause && ev == rcs_pkg::rcs_ev_none &&
			state == rcs_pkg::rcs_st_run) |=>
			reset_cause_reg == $past(hwdata[7:0]) &&
			state == rcs_pkg::rcs_st_run)
		else $error("software write misbehaved");
	chk_wake_no_reset: assert property (
		wake |=> pc_load && !core_reset)
		else $error("wake caused a reset or no load");
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the reset cause and start-up sequencer.
// Assumes the design package and register header compile before this file.
`timescale 1ns/1ps
`include "rcs_regs.svh"
module tb_top;
	typedef struct {int code; logic [7:0] cause;} rcs_tb_row_t;
	localparam logic [15:0] cause_a = 16'({`RCS_CAUSE_IDX, 2'h0});
	localparam logic [15:0] bcon_a = 16'({`RCS_BROWNOUT_CONTROL_IDX, 2'h0});
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [15:0] haddr = 16'h0;
	logic [1:0] htrans = 2'h0, brownout_config = 2'h1;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, rd;
	logic hreadyout, hresp, core_reset, pc_load, vector_high, status_load;
	logic brownout_detector_enable;
	logic [7:0] status_mask, status_value;
	rcs_pkg::rcs_pc_t pc_sel;
	logic por_active = 0, bor_active = 0, prog_mode_exit = 0;
	logic ext_reset_pin_n = 0, pin_reset_enable = 1;
	logic powerup_timer_disable_n = 0, osc_startup_required = 1;
	logic osc_startup_done = 1, stack_reset_enable = 1;
	logic stack_overflow = 0, stack_underflow = 0, reset_instr = 0;
	logic wdt_timeout = 0, watchdog_clear_op = 0, wdt_window_closed = 1;
	logic sleeping = 0, int_wakeup = 0, global_int_enable = 0;
	logic int_high_priority = 0, regulator_fault = 0, fuse_fault = 0;
	logic brownout_circuit_ready = 1;
	int mismatches = 0, comparisons = 0, n;
	// Soft events, cumulative effect on the cause register from 0x3d.
	rcs_tb_row_t rows[8] = '{'{0, 8'h39}, '{1, 8'h31}, '{2, 8'h21},
		'{3, 8'h01}, '{4, 8'h81}, '{5, 8'hc1}, '{6, 8'hc1}, '{7, 8'h33}};

	always #4 hclk = ~hclk;

	rcs_sequencer #(.POWERUP_TIMER_TICKS(4), .SLOW_DIV(2), .PIN_DLY(10))
		rcs_sequencer_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hrdata, .hreadyout, .hresp, .por_active,
		.bor_active, .prog_mode_exit, .ext_reset_pin_n, .pin_reset_enable,
		.powerup_timer_disable_n, .osc_startup_required, .osc_startup_done,
		.stack_reset_enable, .stack_overflow, .stack_underflow, .reset_instr,
		.wdt_timeout, .watchdog_clear_op, .wdt_window_closed, .sleeping,
		.int_wakeup, .global_int_enable, .int_high_priority, .regulator_fault,
		.fuse_fault, .brownout_config, .brownout_circuit_ready, .core_reset,
		.pc_load, .pc_sel, .vector_high, .status_load, .status_mask,
		.status_value, .brownout_detector_enable);

	// ======================================================================
	// Shared tasks.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [15:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	task automatic drive(input int c, input logic v);
		case (c)
			0: reset_instr <= v;
			1: ext_reset_pin_n <= !v;
			2: wdt_timeout <= v;
			3: watchdog_clear_op <= v;
			4: stack_overflow <= v;
			5: stack_underflow <= v;
			6: fuse_fault <= v;
			7: regulator_fault <= v;
			8: int_wakeup <= v;
			default: prog_mode_exit <= v;
		endcase
	endtask

	// Leaves the caller one settled step after the edge that saw the pulse.
	task automatic pulse(input int c);
		@(posedge hclk);
		drive(c, 1'b1);
		@(posedge hclk);
		drive(c, 1'b0);
		#1;
	endtask

	task automatic wait_run();
		n = 0;
		while (core_reset !== 1'b0 && n < 200) begin
			@(posedge hclk);
			#1;
			n++;
		end
		chk(core_reset, 1'b0);
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ======================================================================
	// Cycle budget is a few hundred; the limit leaves ample margin.
	initial begin
		#100us;
		mismatches++;
		stop_test();
	end

	initial begin
		repeat (3) @(posedge hclk);
		chk(core_reset, 1'b1);
		chk(hreadyout, 1'b1);
		chk(hresp, 1'b0);
		hresetn <= 1'b1;
		// Pin held low while both timers expire.
		repeat (60) @(posedge hclk);
		#1;
		chk(core_reset, 1'b1);
		@(posedge hclk);
		ext_reset_pin_n <= 1'b1;
		n = 0;
		do begin
			@(posedge hclk);
			#1;
			n++;
		end while (core_reset !== 1'b0 && n < 50);
		chk(n, 11);
		bus(0, cause_a, 0, rd);
		chk(rd, 32'h3d);
		$display("start-up done");
		for (int i = 0; i < 8; i++) begin
			pulse(rows[i].code);
			chk(core_reset, 1'b1);
			wait_run();
			bus(0, cause_a, 0, rd);
			chk(rd, {24'h0, rows[i].cause});
		end
		$display("event rows done");
		sleeping <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			global_int_enable <= i == 2;
			int_high_priority <= i == 2;
			pulse(i ? 8 : 2);
			chk(core_reset, 1'b0);
			chk(pc_load, 1'b1);
			if (i == 2)
				chk(pc_sel, rcs_pkg::rcs_pc_vector);
			else
				chk(pc_sel, rcs_pkg::rcs_pc_next);
			chk(vector_high, i == 2);
			chk(status_load, 1'b1);
			chk(status_mask, i ? 8'h68 : 8'h60);
			chk(status_value, i ? 8'h40 : 8'h00);
		end
		sleeping <= 1'b0;
		bus(0, cause_a, 0, rd);
		chk(rd, 32'h33);
		$display("wake tests done");
		bus(1, cause_a, 32'h3f, rd);
		bus(0, cause_a, 0, rd);
		chk(rd, 32'h3f);
		bus(1, cause_a, 32'hff, rd);
		bus(0, cause_a, 0, rd);
		chk(rd, 32'hff);
		chk(core_reset, 1'b0);
		bus(0, 16'h0010, 0, rd);
		chk(rd, 32'h0);
		bus(0, bcon_a, 0, rd);
		chk(rd, 32'h81);
		chk(brownout_detector_enable, 1'b1);
		bus(1, bcon_a, 32'h01, rd);
		repeat (2) @(posedge hclk);
		bus(0, bcon_a, 0, rd);
		chk(rd, 32'h00);
		chk(brownout_detector_enable, 1'b0);
		brownout_config <= 2'h3;
		repeat (2) @(posedge hclk);
		#1;
		chk(brownout_detector_enable, 1'b1);
		brownout_config <= 2'h1;
		stack_reset_enable <= 1'b0;
		pulse(4);
		chk(core_reset, 1'b0);
		$display("register tests done");
		pulse(9);
		chk(status_mask, 8'h7f);
		chk(status_value, 8'h60);
		wait_run();
		bus(0, cause_a, 0, rd);
		chk(rd, 32'h3d);
		bus(0, bcon_a, 0, rd);
		chk(rd[7], 1'b1);
		$display("programming exit done");
		stop_test();
	end
endmodule
